// ===== rtl/can_filter_regs.vh
`ifndef CAN_FILTER_REGS_VH
`define CAN_FILTER_REGS_VH

// register word indices (byte address = 4 * index)
`define OFS_FILTER_ENABLE      7'h00
`define OFS_BUF_PTR_0_3        7'h01
`define OFS_BUF_PTR_4_7        7'h02
`define OFS_BUF_PTR_8_11       7'h03
`define OFS_BUF_PTR_12_15      7'h04
`define OFS_MASK_SEL_0_7       7'h05
`define OFS_MASK_SEL_8_15      7'h06
`define OFS_MASK_SID_BASE      7'h08
`define OFS_MASK_EID_BASE      7'h0C
`define OFS_RX_FULL            7'h10
`define OFS_LAST_HIT           7'h11
`define OFS_FILT_SID_BASE      7'h20
`define OFS_FILT_EID_BASE      7'h30

// field positions in the standard identifier word
`define SID_MSB                15
`define SID_LSB                5
`define FRAME_TYPE_BIT         3
`define SID_WRITE_MASK         16'hFFEB

// reset values
`define RST_FILTER_ENABLE      16'hFFFF
`define RST_BUF_PTR            16'h0000
`define RST_MASK_SEL           16'h0000

// pointer value that routes to the receive fifo
`define PTR_FIFO               4'hF

// read latency of the register slave in cycles
`define BUS_WAIT_CYCLES        2'h1

`endif

// ===== rtl/can_filter_match.v
`include "can_filter_regs.vh"

// one filter compare against a selected mask
module can_filter_match (
	input  wire [15:0] filt_sid,
	input  wire [15:0] filt_eid,
	input  wire [15:0] mask_sid,
	input  wire [15:0] mask_eid,
	input  wire        enable,
	input  wire [28:0] frame_id,
	input  wire        frame_ext,
	output wire        hit
);
	wire [28:0] filt_id;
	wire [28:0] mask_id;
	wire        id_ok;
	wire        type_ok;

	// identifier layout: sid(11) then extended high(2) and low(16)
	assign filt_id = {filt_sid[15:5], filt_sid[1:0], filt_eid};
	// a standard frame compares only sid bits; extended bits are don't-care
	assign mask_id = {mask_sid[15:5], {18{frame_ext}} & {mask_sid[1:0], mask_eid}};
	assign id_ok   = ~|((filt_id ^ frame_id) & mask_id);
	// frame-type check on the mask gates the filter's frame-type select
	assign type_ok = ~mask_sid[`FRAME_TYPE_BIT] |
	                 (filt_sid[`FRAME_TYPE_BIT] == frame_ext);
	assign hit     = enable & id_ok & type_ok;
endmodule // can_filter_match

// ===== rtl/can_filter_prio.v
// lowest-numbered hit wins
module can_filter_prio (
	input  wire [15:0] hits,
	output reg         any,
	output reg  [3:0]  index
);
	integer i;

	// scan downward so the lowest set bit is last assigned
	always @* begin
		any   = |hits;
		index = 4'h0;
		for (i = 15; i >= 0; i = i - 1) begin
			if (hits[i]) begin
				index = i[3:0];
			end
		end
	end
endmodule // can_filter_prio

// ===== rtl/can_acceptance_filter_router.v
`include "can_filter_regs.vh"

// What this block does
// - sixteen filters 0..15, each with standard and extended identifier registers
// - pointer all ones sends the accepted frame to the receive fifo
// - pointer 0..14 sends the accepted frame to that numbered buffer
// - pointers for filters 8..15 four per register, highest filter in top nibble
// - 11-bit standard id in bits 15-5; unmasked bits must equal frame bits
// - 18-bit extended id: high two bits in sid word 1-0, low in eid word
// - with type check set, bit 3 picks extended (1) or standard (0) frames
// - with type check clear, frame type ignored, either format may match
// - bits 4 and 2 of the standard id register read as zero
// - two-bit mask source: 00 mask 0, 01 mask 1, 10 mask 2
// - mask sources for filters 0..7 in one register, filter 7 at top
// - mask bit one compares that id bit, zero makes it don't-care
// - mask type check bit forces frame format to agree with filter select
// - only enabled filters can hit
// - storing into a buffer sets its full flag, software clears it
module can_acceptance_filter_router (
	input  wire        SYS_CLK,
	input  wire        SYS_RST,
	input  wire [8:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	input  wire        RX_FRAME_VALID,
	input  wire [28:0] RX_FRAME_ID,
	input  wire        RX_FRAME_EXT,
	output reg         ACCEPT_VALID,
	output reg         ACCEPT_TO_FIFO,
	output reg  [3:0]  ACCEPT_BUFFER,
	output reg  [3:0]  ACCEPT_FILTER
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ACK  = 2'h1;
	localparam ST_DONE = 2'h2;

	// filter identifier words carry no reset value
	reg  [15:0] filt_sid_mem [0:15];
	reg  [15:0] filt_eid_mem [0:15];
	reg  [15:0] mask_sid_mem [0:2];
	reg  [15:0] mask_eid_mem [0:2];
	reg  [15:0] filter_enable_reg;
	reg  [63:0] buf_ptr_reg;
	reg  [31:0] mask_sel_reg;
	reg  [15:0] rx_full_reg;
	reg  [15:0] rx_full_next;
	reg  [7:0]  last_hit_reg;
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [31:0] rdata_next;
	reg  [1:0]  sel_tmp;

	wire [6:0]  word_idx;
	wire [15:0] wdata;
	wire [15:0] hits;
	wire        any_hit;
	wire [3:0]  win_idx;
	wire [3:0]  win_ptr;
	wire        bus_req;
	wire        wr_take;
	wire        byte_lo;
	wire        byte_hi;
	// address decode and frame strobes shared by several processes
	wire        rd_take;
	wire        sel_filt_sid;
	wire        sel_filt_eid;
	wire        sel_mask_sid;
	wire        sel_mask_eid;
	wire        frame_take;
	wire        route_fifo;
	wire [15:0] clr_keep;

	assign word_idx = AVS_ADDRESS[8:2];
	assign wdata    = AVS_WRITEDATA[15:0];
	assign byte_lo  = AVS_BYTEENABLE[0];
	assign byte_hi  = AVS_BYTEENABLE[1];
	assign bus_req  = AVS_READ | AVS_WRITE;
	// a write lands at the edge where waitrequest is seen low, i.e. in the ack state
	assign wr_take  = AVS_WRITE & (state_reg == ST_ACK);
	// read data is captured at the taking edge and stands through the ack cycle
	assign rd_take  = AVS_READ & (state_reg == ST_IDLE);

	// merge a 16-bit write into a stored word under the byte enables
	function [15:0] merge16;
		input [15:0] old_val;
		input [15:0] new_val;
		input        lo;
		input        hi;
		begin
			merge16 = {hi ? new_val[15:8] : old_val[15:8], lo ? new_val[7:0] : old_val[7:0]};
		end
	endfunction

	// two-bit mask source field for filter n
	function [1:0] mask_sel_of;
		input [31:0] sel;
		input integer n;
		begin
			mask_sel_of = sel[n * 2 +: 2];
		end
	endfunction

	// reserved mask source 11 folds onto mask 0 rather than reading a fourth mask
	function [1:0] mask_pick;
		input [1:0] sel;
		begin
			mask_pick = (sel == 2'h3) ? 2'h0 : sel;
		end
	endfunction

	// true when a word index falls inside a block of count words at base
	function in_block;
		input [6:0] idx;
		input [6:0] base;
		input [6:0] count;
		begin
			in_block = (idx >= base) && (idx < base + count);
		end
	endfunction

	// standard identifier words hold nothing in bits 4 and 2
	function [15:0] sid_clean;
		input [15:0] val;
		begin
			sid_clean = val & `SID_WRITE_MASK;
		end
	endfunction

	// four-bit destination pointer for filter n
	function [3:0] ptr_of;
		input [63:0] ptrs;
		input [3:0]  n;
		begin
			ptr_of = ptrs[{n, 2'h0} +: 4];
		end
	endfunction

	// per-filter compare; reserved mask source 11 is treated as mask 0
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : gen_filt
			wire [1:0] sel = mask_sel_of(mask_sel_reg, g);
			wire [1:0] msk = mask_pick(sel);
			can_filter_match u_match (
				.filt_sid  (filt_sid_mem[g]),
				.filt_eid  (filt_eid_mem[g]),
				.mask_sid  (mask_sid_mem[msk]),
				.mask_eid  (mask_eid_mem[msk]),
				.enable    (filter_enable_reg[g]),
				.frame_id  (RX_FRAME_ID),
				.frame_ext (RX_FRAME_EXT),
				.hit       (hits[g])
			);
		end
	endgenerate

	can_filter_prio u_prio (
		.hits  (hits),
		.any   (any_hit),
		.index (win_idx)
	);

	assign win_ptr = ptr_of(buf_ptr_reg, win_idx);

	// address decode of the identifier and mask word blocks
	assign sel_filt_sid = in_block(word_idx, `OFS_FILT_SID_BASE, 7'h10);
	assign sel_filt_eid = in_block(word_idx, `OFS_FILT_EID_BASE, 7'h10);
	assign sel_mask_sid = in_block(word_idx, `OFS_MASK_SID_BASE, 7'h03);
	assign sel_mask_eid = in_block(word_idx, `OFS_MASK_EID_BASE, 7'h03);

	// a frame is taken when it is strobed and some enabled filter hits
	assign frame_take = RX_FRAME_VALID & any_hit;
	assign route_fifo = (win_ptr == `PTR_FIFO);
	assign clr_keep   = merge16(16'hFFFF, wdata, byte_lo, byte_hi);

	// bus handshake: an access taken in idle waits one cycle, then acks; the done state adds one rest cycle before the next
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (bus_req) begin
					state_next = ST_ACK;
				end
			end
			ST_ACK: begin
				state_next = ST_DONE;
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// read mux; unmapped words read as zero
	always @* begin
		rdata_next = 32'h00000000;
		sel_tmp    = 2'h0;
		if (sel_filt_sid) begin
			rdata_next[15:0] = sid_clean(filt_sid_mem[word_idx[3:0]]);
		end else if (sel_filt_eid) begin
			rdata_next[15:0] = filt_eid_mem[word_idx[3:0]];
		end else if (sel_mask_sid) begin
			sel_tmp          = word_idx[1:0];
			rdata_next[15:0] = sid_clean(mask_sid_mem[sel_tmp]);
		end else if (sel_mask_eid) begin
			sel_tmp          = word_idx[1:0];
			rdata_next[15:0] = mask_eid_mem[sel_tmp];
		end else begin
			case (word_idx)
				`OFS_FILTER_ENABLE:  rdata_next[15:0] = filter_enable_reg;
				`OFS_BUF_PTR_0_3:    rdata_next[15:0] = buf_ptr_reg[15:0];
				`OFS_BUF_PTR_4_7:    rdata_next[15:0] = buf_ptr_reg[31:16];
				`OFS_BUF_PTR_8_11:   rdata_next[15:0] = buf_ptr_reg[47:32];
				`OFS_BUF_PTR_12_15:  rdata_next[15:0] = buf_ptr_reg[63:48];
				`OFS_MASK_SEL_0_7:   rdata_next[15:0] = mask_sel_reg[15:0];
				`OFS_MASK_SEL_8_15:  rdata_next[15:0] = mask_sel_reg[31:16];
				`OFS_RX_FULL:        rdata_next[15:0] = rx_full_reg;
				`OFS_LAST_HIT:       rdata_next[15:0] = {8'h00, last_hit_reg};
				default:             rdata_next = 32'h00000000;
			endcase
		end
	end

	// full flags: hardware set wins over a software clear in the same cycle
	always @* begin
		rx_full_next = rx_full_reg;
		// software clears a flag by writing zero to it in an enabled byte
		if (wr_take && word_idx == `OFS_RX_FULL) begin
			rx_full_next = rx_full_reg & clr_keep;
		end
		if (frame_take && !route_fifo) begin
			rx_full_next[win_ptr] = 1'b1;
		end
	end

	// bus slave handshake: waitrequest and read data come straight from flops
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg       <= ST_IDLE;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
		end else begin
			state_reg       <= state_next;
			AVS_WAITREQUEST <= ~(state_next == ST_ACK);
			if (rd_take) begin
				AVS_READDATA <= rdata_next;
			end
		end
	end

	// receive buffer full flags; only reset or software clears them
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_full_reg <= 16'h0000;
		end else begin
			rx_full_reg <= rx_full_next;
		end
	end

	// control registers, written under the byte enables at the acked edge
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			filter_enable_reg <= `RST_FILTER_ENABLE;
			buf_ptr_reg       <= {4{`RST_BUF_PTR}};
			mask_sel_reg      <= {2{`RST_MASK_SEL}};
		end else begin
			if (wr_take) begin
				case (word_idx)
					`OFS_FILTER_ENABLE:  filter_enable_reg  <= merge16(filter_enable_reg, wdata, byte_lo, byte_hi);
					`OFS_BUF_PTR_0_3:    buf_ptr_reg[15:0]  <= merge16(buf_ptr_reg[15:0], wdata, byte_lo, byte_hi);
					`OFS_BUF_PTR_4_7:    buf_ptr_reg[31:16] <= merge16(buf_ptr_reg[31:16], wdata, byte_lo, byte_hi);
					`OFS_BUF_PTR_8_11:   buf_ptr_reg[47:32] <= merge16(buf_ptr_reg[47:32], wdata, byte_lo, byte_hi);
					`OFS_BUF_PTR_12_15:  buf_ptr_reg[63:48] <= merge16(buf_ptr_reg[63:48], wdata, byte_lo, byte_hi);
					`OFS_MASK_SEL_0_7:   mask_sel_reg[15:0] <= merge16(mask_sel_reg[15:0], wdata, byte_lo, byte_hi);
					`OFS_MASK_SEL_8_15:  mask_sel_reg[31:16] <= merge16(mask_sel_reg[31:16], wdata, byte_lo, byte_hi);
					default: begin
					end
				endcase
			end
		end
	end

	// identifier and mask memories have no reset, so they stay undefined until written
	// filter standard words drop bits 4 and 2 on the way in
	always @(posedge SYS_CLK) begin
		if (wr_take && sel_filt_sid) begin
			filt_sid_mem[word_idx[3:0]] <= sid_clean(merge16(filt_sid_mem[word_idx[3:0]], wdata,
			                                                 byte_lo, byte_hi));
		end
	end

	// filter extended words
	always @(posedge SYS_CLK) begin
		if (wr_take && sel_filt_eid) begin
			filt_eid_mem[word_idx[3:0]] <= merge16(filt_eid_mem[word_idx[3:0]], wdata, byte_lo, byte_hi);
		end
	end

	// mask standard words, same unimplemented bits as the filters
	always @(posedge SYS_CLK) begin
		if (wr_take && sel_mask_sid) begin
			mask_sid_mem[word_idx[1:0]] <= sid_clean(merge16(mask_sid_mem[word_idx[1:0]], wdata,
			                                                 byte_lo, byte_hi));
		end
	end

	// mask extended words
	always @(posedge SYS_CLK) begin
		if (wr_take && sel_mask_eid) begin
			mask_eid_mem[word_idx[1:0]] <= merge16(mask_eid_mem[word_idx[1:0]], wdata, byte_lo, byte_hi);
		end
	end

	// routing result, registered one cycle after the frame strobe
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ACCEPT_VALID   <= 1'b0;
			ACCEPT_TO_FIFO <= 1'b0;
			ACCEPT_BUFFER  <= 4'h0;
			ACCEPT_FILTER  <= 4'h0;
		end else begin
			ACCEPT_VALID <= frame_take;
			if (frame_take) begin
				ACCEPT_TO_FIFO <= route_fifo;
				ACCEPT_BUFFER  <= win_ptr;
				ACCEPT_FILTER  <= win_idx;
			end
		end
	end

	// last accepted filter index and fifo flag for software; the top bit marks that one was seen
	always @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			last_hit_reg <= 8'h00;
		end else if (frame_take) begin
			last_hit_reg <= {3'h4, route_fifo, win_idx};
		end
	end
endmodule // can_acceptance_filter_router

// ===== dv/can_filter_router_monitor.sv
module can_filter_router_monitor (
	input wire logic        SYS_CLK,
	input wire logic        SYS_RST,
	input wire logic [8:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        RX_FRAME_VALID,
	input wire logic        ACCEPT_VALID,
	input wire logic        ACCEPT_TO_FIFO,
	input wire logic [3:0]  ACCEPT_BUFFER,
	input wire logic [3:0]  ACCEPT_FILTER
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking mon_cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// a request is busy at the taking edge, acked at the next, then busy again
	sequence ack_walk;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	sequence bus_idle2;
		!(AVS_READ || AVS_WRITE) ##1 !(AVS_READ || AVS_WRITE);
	endsequence
	ack_walk_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> ack_walk)
		else $error("bus answer out of step");
	ack_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
		else $error("ack without request");
	idle_busy_a: assert property (bus_idle2 |-> AVS_WAITREQUEST)
		else $error("waitrequest low while idle");
	sid_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[8:6] == 3'h2 |->
		AVS_READDATA[4] == 1'b0 && AVS_READDATA[2] == 1'b0) else $error("unimplemented id bits read one");
	upper_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
		else $error("upper read data not zero");
	accept_cause_a: assert property (ACCEPT_VALID |-> $past(RX_FRAME_VALID))
		else $error("accept without a frame");
	fifo_route_a: assert property (ACCEPT_VALID |-> ACCEPT_TO_FIFO == (ACCEPT_BUFFER == 4'hF))
		else $error("fifo flag disagrees with pointer");
	// destination fields stand between accepts
	hold_dest_a: assert property (!ACCEPT_VALID |-> $stable(ACCEPT_BUFFER) && $stable(ACCEPT_FILTER))
		else $error("destination changed without accept");
endmodule // can_filter_router_monitor

bind can_acceptance_filter_router can_filter_router_monitor i_can_filter_router_monitor (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.RX_FRAME_VALID(RX_FRAME_VALID), .ACCEPT_VALID(ACCEPT_VALID), .ACCEPT_TO_FIFO(ACCEPT_TO_FIFO),
	.ACCEPT_BUFFER(ACCEPT_BUFFER), .ACCEPT_FILTER(ACCEPT_FILTER));

// ===== dv/can_frame_source.sv
module can_frame_source (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [28:0] id,
	input  wire logic        ext,
	output logic             valid,
	output logic      [28:0] frame_id,
	output logic             frame_ext
);
	timeunit 1ns;
	timeprecision 1ps;
	// one-cycle frame; outside it the id lines toggle so stale values never pass
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			valid <= 1'b0;
			frame_id <= 29'h00000000;
			frame_ext <= 1'b0;
		end else begin
			valid <= go;
			frame_id <= go ? id : ~frame_id;
			frame_ext <= go ? ext : ~frame_ext;
		end
	end
endmodule // can_frame_source

// ===== dv/testbench.sv
`include "can_filter_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic SYS_CLK = 0, SYS_RST = 1, AVS_READ = 0, AVS_WRITE = 0, go = 0, gext = 0;
	logic [8:0] AVS_ADDRESS = 0;
	logic [31:0] AVS_WRITEDATA = 0, q;
	logic [3:0] AVS_BYTEENABLE = 0;
	logic [28:0] gid = 0;
	wire [31:0] AVS_READDATA;
	wire AVS_WAITREQUEST, RX_FRAME_VALID, RX_FRAME_EXT, ACCEPT_VALID, ACCEPT_TO_FIFO;
	wire [28:0] RX_FRAME_ID;
	wire [3:0] ACCEPT_BUFFER, ACCEPT_FILTER;
	logic [15:0] fsid[16], feid[16], msid[3], meid[3], bp[4], ms[2], en, full;
	logic [7:0] lh = 8'h00;
	int miscompares = 0, comparisons = 0, cycles = 0;

	can_acceptance_filter_router i_can_acceptance_filter_router (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME_ID(RX_FRAME_ID), .RX_FRAME_EXT(RX_FRAME_EXT),
		.ACCEPT_VALID(ACCEPT_VALID), .ACCEPT_TO_FIFO(ACCEPT_TO_FIFO), .ACCEPT_BUFFER(ACCEPT_BUFFER),
		.ACCEPT_FILTER(ACCEPT_FILTER));
	can_frame_source i_can_frame_source (.clk(SYS_CLK), .rst(SYS_RST), .go(go), .id(gid), .ext(gext),
		.valid(RX_FRAME_VALID), .frame_id(RX_FRAME_ID), .frame_ext(RX_FRAME_EXT));

	always #4 SYS_CLK = ~SYS_CLK;
	// 40 configs of about 300 cycles each; ceiling leaves a wide margin
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk_reg(input string nm, input logic [15:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== {16'h0000, e}) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_acc(input logic [9:0] e, input logic [9:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch accept expected %h seen %h", e, g);
		end
	endtask
	// one bus cycle; holds the request until waitrequest is sampled low, then rests an edge
	task rw(input logic w, input logic [6:0] i, input logic [15:0] d, output logic [31:0] r);
		AVS_ADDRESS <= {i, 2'b00};
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= {16'h0000, d};
		AVS_BYTEENABLE <= 4'h3;
		do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
		r = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task put(input logic [6:0] i, input logic [15:0] d, input logic [15:0] rmask);
		rw(1'b1, i, d, q);
		rw(1'b0, i, 16'h0000, q);
		chk_reg("register", d & rmask, q);
	endtask
	// lowest enabled matching filter wins: {valid, fifo, pointer, filter}
	function automatic logic [9:0] ref_acc(input logic [28:0] id, input logic x);
		logic [1:0] m;
		logic [9:0] r;
		r = 10'h000;
		for (int f = 15; f >= 0; f--) begin
			m = ms[f / 8][(f % 8) * 2 +: 2];
			if (en[f] && ((id[28:18] ^ fsid[f][15:5]) & msid[m][15:5]) == 11'h000
				&& (!x || (({fsid[f][1:0], feid[f]} ^ id[17:0]) & {msid[m][1:0], meid[m]}) == 18'h00000)
				&& (!msid[m][3] || fsid[f][3] == x))
				r = {1'b1, bp[f / 4][(f % 4) * 4 +: 4] == 4'hF, bp[f / 4][(f % 4) * 4 +: 4], 4'(f)};
		end
		return r;
	endfunction
	task send(input logic [28:0] id, input logic x);
		logic [9:0] e;
		e = ref_acc(id, x);
		gid <= id;
		gext <= x;
		go <= 1'b1;
		@(posedge SYS_CLK);
		go <= 1'b0;
		@(posedge SYS_CLK);
		#1;
		chk_acc(e[9] ? e : 10'h000, ACCEPT_VALID ? {ACCEPT_VALID, ACCEPT_TO_FIFO, ACCEPT_BUFFER, ACCEPT_FILTER}
			: 10'h000);
		if (e[9] && e[7:4] != 4'hF) full[e[7:4]] = 1'b1;
		if (e[9]) lh = {3'h4, e[8], e[3:0]};
		@(posedge SYS_CLK);
	endtask

	initial begin
		int f;
		void'($urandom(66));
		repeat (12) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		@(posedge SYS_CLK);
		rw(1'b0, `OFS_FILTER_ENABLE, 16'h0000, q);
		chk_reg("enable", 16'hFFFF, q);
		// pointers and mask selects clear; word 07 is unmapped
		for (int i = 1; i < 8; i++) begin
			rw(1'b0, 7'(i), 16'h0000, q);
			chk_reg("reset", 16'h0000, q);
		end
		full = 16'h0000;
		for (int t = 0; t < 40; t++) begin
			en = t == 0 ? 16'h0000 : 16'($urandom);
			for (int i = 0; i < 4; i++) bp[i] = t == 1 ? 16'hFFFF : 16'($urandom);
			for (int j = 0; j < 16; j++) ms[j / 8][(j % 8) * 2 +: 2] = 2'($urandom_range(2));
			for (int i = 0; i < 3; i++) begin
				msid[i] = 16'($urandom);
				meid[i] = 16'($urandom & $urandom);
			end
			for (int i = 0; i < 16; i++) begin
				fsid[i] = 16'($urandom);
				feid[i] = 16'($urandom);
			end
			put(`OFS_FILTER_ENABLE, en, 16'hFFFF);
			for (int i = 0; i < 4; i++) put(`OFS_BUF_PTR_0_3 + 7'(i), bp[i], 16'hFFFF);
			for (int i = 0; i < 2; i++) put(`OFS_MASK_SEL_0_7 + 7'(i), ms[i], 16'hFFFF);
			for (int i = 0; i < 3; i++) put(`OFS_MASK_SID_BASE + 7'(i), msid[i], `SID_WRITE_MASK);
			for (int i = 0; i < 3; i++) put(`OFS_MASK_EID_BASE + 7'(i), meid[i], 16'hFFFF);
			for (int i = 0; i < 16; i++) put(`OFS_FILT_SID_BASE + 7'(i), fsid[i], `SID_WRITE_MASK);
			for (int i = 0; i < 16; i++) put(`OFS_FILT_EID_BASE + 7'(i), feid[i], 16'hFFFF);
			// mostly frames copied from a filter, so hits and overlaps are common
			for (int k = 0; k < 4; k++) begin
				f = $urandom_range(15);
				if (k < 3) send({fsid[f][15:5], fsid[f][1:0], feid[f]}, fsid[f][3]);
				else send(29'($urandom), 1'($urandom));
			end
			rw(1'b0, `OFS_LAST_HIT, 16'h0000, q);
			chk_reg("last hit", {8'h00, lh}, q);
			rw(1'b0, `OFS_RX_FULL, 16'h0000, q);
			chk_reg("full", full, q);
			// a zero in an enabled byte clears that flag, a one leaves it
			f = int'($urandom);
			rw(1'b1, `OFS_RX_FULL, 16'(f), q);
			full = full & 16'(f);
			rw(1'b0, `OFS_RX_FULL, 16'h0000, q);
			chk_reg("full", full, q);
		end
		print_verdict();
	end
endmodule // testbench
